/* rtl/bsmh_initiator.sv */
// Initiator-side message phase handler: sends and checks message bytes over REQ/ACK.
// Assumes a target drives REQ, BSY and the phase lines; software uses the plain register port.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module bsmh_initiator (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bsmh_pkg::bsmh_sw_req_type sw_req_i,
  output logic [31:0] rd_data_o,
  input wire bsmh_pkg::bsmh_pins_type pins_i,
  output logic [7:0] db_o,
  output logic dbp_o,
  output logic db_oe_o,
  output logic ack_o,
  output logic atn_o,
  output logic ptr_restore_o,
  output logic ptr_reset_o
);

  // ==========================================================================
  // Decoding helpers.
  function automatic logic [3:0] residue_lanes(input logic [7:0] count, input logic wide32);
    logic [3:0] lanes;
    lanes = 4'h0;
    if (wide32) begin
      if (count == bsmh_pkg::RES_ONE) lanes = 4'h8;
      else if (count == bsmh_pkg::RES_TWO) lanes = 4'hC;
      else if (count == bsmh_pkg::RES_THREE) lanes = 4'hE;
    end else begin
      lanes = 4'hC;
      if (count == bsmh_pkg::RES_ONE) lanes = 4'hE;
    end
    return lanes;
  endfunction

  function automatic logic residue_valid(input logic [7:0] count, input logic wide32);
    return (residue_lanes(count, wide32) & (wide32 ? 4'hF : 4'h3)) != 4'h0;
  endfunction

  // ==========================================================================
  // Pin synchronisation and phase decode.
  bsmh_pkg::bsmh_pins_type s;

  bsmh_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins_i),
    .pins_o(s)
  );

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACK} bsmh_hs_type;

  bsmh_hs_type state_reg;
  logic out_mode_reg;
  logic phase_in;
  logic phase_out;
  logic bus_free;
  logic rx_take;
  logic tx_done;
  logic tx_last;

  assign phase_in = s.msg && s.cd && s.io;
  assign phase_out = s.msg && s.cd && !s.io;
  assign bus_free = !s.bsy;
  assign rx_take = (state_reg == ST_IDLE) && s.req && s.bsy && phase_in;
  assign tx_done = (state_reg == ST_ACK) && !s.req && out_mode_reg;

  // ==========================================================================
  // Registers.
  logic [7:0] ctrl_reg;
  logic [7:0] tx0_reg;
  logic [7:0] tx1_reg;
  logic [1:0] tx_len_reg;
  logic tx_idx_reg;
  logic locked_reg;
  logic lock_sel_reg;
  logic [2:0] lock_num_reg;
  logic ident_ok_reg;
  logic recovery_reg;
  logic nexus_err_reg;
  logic target_rej_reg;
  logic parity_seen_reg;
  logic exp_count_reg;
  logic exp_tag_code_reg;
  logic exp_tag_val_reg;
  logic [7:0] last_rx_reg;
  logic [3:0] lanes_reg;
  logic [7:0] restore_cnt_reg;
  logic [7:0] reset_cnt_reg;

  assign tx_last = (tx_len_reg != 2'd0) && ({1'b0, tx_idx_reg} + 2'd1 == tx_len_reg);

  // ==========================================================================
  // Receive decision.
  logic par_ok;
  logic is_ident;
  logic rx_reject;
  logic ident_good;
  logic do_restore;
  logic do_reset;
  logic cmd_wr;
  logic sw_ident;
  logic clear_cmd;
  logic [7:0] sw_ident_byte;

  assign par_ok = ^{s.db, s.dbp};
  assign is_ident = s.db[bsmh_pkg::IDENT_BIT] && !exp_count_reg && !exp_tag_val_reg;
  assign cmd_wr = sw_req_i.wr && (sw_req_i.addr == bsmh_pkg::ADDR_CMD);
  assign clear_cmd = cmd_wr && sw_req_i.wdata[bsmh_pkg::CMD_CLEAR];
  assign sw_ident_byte = {1'b1, ctrl_reg[bsmh_pkg::CTRL_DISC], ctrl_reg[bsmh_pkg::CTRL_SEL], 2'b00,
                          ctrl_reg[bsmh_pkg::CTRL_NUM_LSB +: 3]};

  always_comb begin
    rx_reject = 1'b0;
    ident_good = 1'b0;
    if (is_ident) begin
      rx_reject = s.db[bsmh_pkg::DISC_BIT] || s.db[bsmh_pkg::RSV_HI_BIT] || s.db[bsmh_pkg::RSV_LO_BIT];
      ident_good = !rx_reject && !atn_o && !ctrl_reg[bsmh_pkg::CTRL_TAGGED];
    end else if (exp_count_reg) begin
      rx_reject = !residue_valid(s.db, ctrl_reg[bsmh_pkg::CTRL_WIDE32]);
    end else if (exp_tag_code_reg) begin
      rx_reject = s.db != bsmh_pkg::MSG_SIMPLE_TAG;
    end else if (exp_tag_val_reg) begin
      ident_good = !atn_o;
    end else if (s.db == bsmh_pkg::MSG_INIT_RECOVERY) begin
      rx_reject = ctrl_reg[bsmh_pkg::CTRL_REFUSE_REC];
    end
  end

  assign do_restore = rx_take && par_ok && ident_good;
  assign do_reset = rx_take && par_ok && !is_ident && !exp_count_reg && !exp_tag_val_reg &&
                    ((s.db == bsmh_pkg::MSG_LINKED) || (s.db == bsmh_pkg::MSG_LINKED_FLAG));

  // Identify from software is refused if it would change the locked nexus.
  assign sw_ident = cmd_wr && sw_req_i.wdata[bsmh_pkg::CMD_IDENT] && (tx_len_reg == 2'd0) &&
                    !(locked_reg && ((lock_sel_reg != ctrl_reg[bsmh_pkg::CTRL_SEL]) ||
                      (lock_num_reg != ctrl_reg[bsmh_pkg::CTRL_NUM_LSB +: 3])));

  // ==========================================================================
  // Handshake engine.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      ack_o <= 1'b0;
      db_o <= 8'h00;
      dbp_o <= 1'b0;
      db_oe_o <= 1'b0;
      out_mode_reg <= 1'b0;
    end else if (bus_free) begin
      state_reg <= ST_IDLE;
      ack_o <= 1'b0;
      db_oe_o <= 1'b0;
      out_mode_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (rx_take) begin
            ack_o <= 1'b1;
            out_mode_reg <= 1'b0;
            state_reg <= ST_ACK;
          end else if (s.req && phase_out) begin
            db_o <= (tx_len_reg == 2'd0) ? bsmh_pkg::MSG_NOP : (tx_idx_reg ? tx1_reg : tx0_reg);
            dbp_o <= ~^((tx_len_reg == 2'd0) ? bsmh_pkg::MSG_NOP : (tx_idx_reg ? tx1_reg : tx0_reg));
            db_oe_o <= 1'b1;
            out_mode_reg <= 1'b1;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          ack_o <= 1'b1;
          state_reg <= ST_ACK;
        end
        ST_ACK: begin
          if (!s.req) begin
            ack_o <= 1'b0;
            db_oe_o <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Outgoing message queue.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx0_reg <= 8'h00;
      tx1_reg <= 8'h00;
      tx_len_reg <= 2'd0;
      tx_idx_reg <= 1'b0;
    end else if (bus_free) begin
      tx_len_reg <= 2'd0;
      tx_idx_reg <= 1'b0;
    end else if (rx_take && (!par_ok || rx_reject)) begin
      tx0_reg <= par_ok ? bsmh_pkg::MSG_REJECT : bsmh_pkg::MSG_PARITY_ERR;
      tx_len_reg <= 2'd1;
      tx_idx_reg <= 1'b0;
    end else if (sw_ident) begin
      tx0_reg <= sw_ident_byte;
      tx1_reg <= sw_req_i.wdata[bsmh_pkg::CMD_TAG_LSB +: 8];
      tx_len_reg <= sw_req_i.wdata[bsmh_pkg::CMD_TAG] ? 2'd2 : 2'd1;
      tx_idx_reg <= 1'b0;
    end else if (tx_done && (tx_len_reg != 2'd0)) begin
      if (tx_last) begin
        tx_len_reg <= 2'd0;
        tx_idx_reg <= 1'b0;
      end else begin
        tx_idx_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Attention line: raised on a bad-parity or rejected byte or a software identify, dropped in the cycle ACK rises for the last byte.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atn_o <= 1'b0;
    end else if (bus_free) begin
      atn_o <= 1'b0;
    end else if ((rx_take && (!par_ok || rx_reject)) || sw_ident) begin
      atn_o <= 1'b1;
    end else if ((state_reg == ST_SETUP) && tx_last) begin
      atn_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Inbound message parsing.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exp_count_reg <= 1'b0;
      exp_tag_code_reg <= 1'b0;
      exp_tag_val_reg <= 1'b0;
      last_rx_reg <= 8'h00;
      lanes_reg <= 4'h0;
    end else if (bus_free) begin
      exp_count_reg <= 1'b0;
      exp_tag_code_reg <= 1'b0;
      exp_tag_val_reg <= 1'b0;
    end else if (rx_take) begin
      last_rx_reg <= s.db;
      // A parity error drops the partial message; the target resends it whole.
      exp_count_reg <= par_ok && !is_ident && !exp_count_reg && !exp_tag_val_reg &&
                       (s.db == bsmh_pkg::MSG_WIDE_RESIDUE);
      exp_tag_code_reg <= par_ok && is_ident && !rx_reject && ctrl_reg[bsmh_pkg::CTRL_TAGGED];
      exp_tag_val_reg <= par_ok && exp_tag_code_reg && !rx_reject;
      if (par_ok && exp_count_reg && !rx_reject) begin
        lanes_reg <= residue_lanes(s.db, ctrl_reg[bsmh_pkg::CTRL_WIDE32]);
      end
    end
  end

  // ==========================================================================
  // Nexus lock and status flags; a setting event wins over a software clear, but bus free wins over a lock.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_reg <= 1'b0;
      lock_sel_reg <= 1'b0;
      lock_num_reg <= 3'd0;
      ident_ok_reg <= 1'b0;
      recovery_reg <= 1'b0;
      nexus_err_reg <= 1'b0;
      target_rej_reg <= 1'b0;
      parity_seen_reg <= 1'b0;
    end else begin
      if (bus_free) begin
        locked_reg <= 1'b0;
        ident_ok_reg <= 1'b0;
      end else if (sw_ident) begin
        locked_reg <= 1'b1;
        lock_sel_reg <= ctrl_reg[bsmh_pkg::CTRL_SEL];
        lock_num_reg <= ctrl_reg[bsmh_pkg::CTRL_NUM_LSB +: 3];
      end else if (rx_take && par_ok && is_ident && !rx_reject) begin
        locked_reg <= 1'b1;
        lock_sel_reg <= s.db[bsmh_pkg::SEL_BIT];
        lock_num_reg <= s.db[bsmh_pkg::NUM_MSB:0];
      end
      if (clear_cmd) begin
        ident_ok_reg <= 1'b0;
        recovery_reg <= 1'b0;
        nexus_err_reg <= 1'b0;
        target_rej_reg <= 1'b0;
        parity_seen_reg <= 1'b0;
      end
      if (do_restore || (out_mode_reg && tx_done && tx_last && locked_reg && !s.msg)) begin
        ident_ok_reg <= 1'b1;
      end
      if (rx_take && par_ok && !rx_reject && !is_ident && !exp_count_reg && !exp_tag_code_reg &&
          !exp_tag_val_reg && (s.db == bsmh_pkg::MSG_INIT_RECOVERY)) begin
        recovery_reg <= 1'b1;
      end
      if (cmd_wr && sw_req_i.wdata[bsmh_pkg::CMD_IDENT] && !sw_ident) begin
        nexus_err_reg <= 1'b1;
      end
      if (rx_take && par_ok && !is_ident && !exp_count_reg && !exp_tag_val_reg &&
          (s.db == bsmh_pkg::MSG_REJECT)) begin
        target_rej_reg <= 1'b1;
      end
      if (rx_take && !par_ok) begin
        parity_seen_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Pointer events.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_restore_o <= 1'b0;
      ptr_reset_o <= 1'b0;
      restore_cnt_reg <= 8'h00;
      reset_cnt_reg <= 8'h00;
    end else begin
      ptr_restore_o <= do_restore;
      ptr_reset_o <= do_reset;
      if (do_restore) restore_cnt_reg <= restore_cnt_reg + 8'h01;
      if (do_reset) reset_cnt_reg <= reset_cnt_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Software register port.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= bsmh_pkg::CTRL_RESET;
    end else if (sw_req_i.wr && (sw_req_i.addr == bsmh_pkg::ADDR_CTRL)) begin
      ctrl_reg <= sw_req_i.wdata[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (sw_req_i.rd) begin
      unique case (sw_req_i.addr)
        bsmh_pkg::ADDR_CTRL: rd_data_o <= {24'h000000, ctrl_reg};
        bsmh_pkg::ADDR_STATUS: rd_data_o <= {16'h0000, 2'b00, tx_len_reg, lock_num_reg, lock_sel_reg,
                                             locked_reg, parity_seen_reg, target_rej_reg, nexus_err_reg,
                                             recovery_reg, ident_ok_reg, atn_o, s.bsy};
        bsmh_pkg::ADDR_RX: rd_data_o <= {20'h00000, lanes_reg, last_rx_reg};
        bsmh_pkg::ADDR_PTR: rd_data_o <= {16'h0000, reset_cnt_reg, restore_cnt_reg};
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

endmodule

/* rtl/bsmh_pkg.sv */
// Constants and carrier types for the initiator-side bus message handler.
// Assumes an 8-bit parallel message bus with odd parity and a 200 MHz system clock.
package bsmh_pkg;

  // ==========================================================================
  // Identify byte layout.
  localparam int IDENT_BIT = 7;
  localparam int DISC_BIT = 6;
  localparam int SEL_BIT = 5;
  localparam int RSV_HI_BIT = 4;
  localparam int RSV_LO_BIT = 3;
  localparam int NUM_MSB = 2;

  // ==========================================================================
  // Message codes.
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] MSG_NOP = 8'h08;
  localparam logic [7:0] MSG_PARITY_ERR = 8'h09;
  localparam logic [7:0] MSG_LINKED = 8'h0A;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0B;
  localparam logic [7:0] MSG_INIT_RECOVERY = 8'h0F;
  localparam logic [7:0] MSG_SIMPLE_TAG = 8'h20;
  localparam logic [7:0] MSG_TAG_HI = 8'h22;
  localparam logic [7:0] MSG_WIDE_RESIDUE = 8'h23;
  localparam logic [7:0] RES_ONE = 8'h01;
  localparam logic [7:0] RES_TWO = 8'h02;
  localparam logic [7:0] RES_THREE = 8'h03;

  // ==========================================================================
  // Software register map and reset values.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_RX = 4'h3;
  localparam logic [3:0] ADDR_PTR = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_DISC = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_NUM_LSB = 2;
  localparam int CTRL_TAGGED = 5;
  localparam int CTRL_WIDE32 = 6;
  localparam int CTRL_REFUSE_REC = 7;
  localparam int CMD_IDENT = 0;
  localparam int CMD_TAG = 1;
  localparam int CMD_CLEAR = 2;
  localparam int CMD_TAG_LSB = 8;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } bsmh_sw_req_type;

  typedef struct packed {
    logic req;
    logic bsy;
    logic msg;
    logic cd;
    logic io;
    logic [7:0] db;
    logic dbp;
  } bsmh_pins_type;

endpackage

/* rtl/bsmh_sync.sv */
// Two-flop synchroniser for the bus pins seen by the message handler.
// Assumes pins are asynchronous to clk_i; the first stage feeds only the second.
`timescale 1ns/1ps
module bsmh_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bsmh_pkg::bsmh_pins_type pins_i,
  output bsmh_pkg::bsmh_pins_type pins_o
);

  // ==========================================================================
  // Synchroniser stages.
  bsmh_pkg::bsmh_pins_type stage_reg [bsmh_pkg::SYNC_STAGES];

  genvar g;
  generate
    for (g = 0; g < bsmh_pkg::SYNC_STAGES; g++) begin : gen_stage
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= (g == 0) ? pins_i : stage_reg[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign pins_o = stage_reg[bsmh_pkg::SYNC_STAGES - 1];

endmodule

/* dv/bsmh_initiator_checker.sv */
// Port assertions for the initiator-side bus message handler.
// Assumes a bind from the bench top; sees only the handler's ports.
`timescale 1ns/1ps
module bsmh_initiator_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bsmh_pkg::bsmh_sw_req_type sw_req_i,
  input wire logic [31:0] rd_data_o,
  input wire bsmh_pkg::bsmh_pins_type pins_i,
  input wire logic [7:0] db_o,
  input wire logic dbp_o,
  input wire logic db_oe_o,
  input wire logic ack_o,
  input wire logic atn_o,
  input wire logic ptr_restore_o,
  input wire logic ptr_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Assertions.
  property p_rd_zero;
    !$past(sw_req_i.rd) |-> rd_data_o == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside its slot");
  property p_parity;
    db_oe_o |-> ^{db_o, dbp_o} == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("driven byte has even parity");
  property p_restore_pulse;
    ptr_restore_o |=> !ptr_restore_o;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse) else $error("restore pulse too long");
  property p_reset_pulse;
    ptr_reset_o |=> !ptr_reset_o;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("pointer reset pulse too long");
  property p_atn_stay;
    ack_o && $past(ack_o) && !db_oe_o |-> !$fell(atn_o);
  endproperty
  a_atn_stay: assert property (p_atn_stay) else $error("attention dropped while acknowledging");
  property p_ack_cause;
    $rose(ack_o) |-> $past(pins_i.req, 2) && $past(pins_i.bsy, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
  property p_ack_release;
    $fell(ack_o) |-> !$past(pins_i.req, 2) || !$past(pins_i.bsy, 2);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge released early");
  property p_ack_time;
    $rose(pins_i.req) && pins_i.bsy |-> ##[2:6] ack_o;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("acknowledge too late");
  property p_oe_ack;
    $rose(db_oe_o) |=> ack_o && db_oe_o;
  endproperty
  a_oe_ack: assert property (p_oe_ack) else $error("outbound byte not acknowledged");
endmodule

/* dv/bsmh_target_model.sv */
// Behavioural target at the far end of the message bus.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/1ps
module bsmh_target_model (
  input wire logic clk_i,
  output bsmh_pkg::bsmh_pins_type pins_o,
  input wire logic [7:0] db_i,
  input wire logic ack_i,
  input wire logic atn_i
);
  int timeouts = 0;
  logic interlock = 1'b0;
  logic recovery = 1'b0;
  initial pins_o = '0;
  // ==========================================================================
  // Bus ownership and identify coding.
  function automatic logic [7:0] ident(input logic [2:0] num);
    return {1'b1, 1'b0, 1'b0, 2'b00, num};
  endfunction
  task automatic connect();
    @(posedge clk_i);
    pins_o.bsy <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic release_bus();
    @(posedge clk_i);
    pins_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~pins_o.db, ~pins_o.dbp};
  endtask
  // ==========================================================================
  // One message byte over the request and acknowledge interlock.
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (ack_i !== lvl && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (ack_i !== lvl) timeouts++;
  endtask
  task automatic xfer(input logic io, input logic [7:0] b, input logic badp, output logic atn,
                      output logic [7:0] got);
    @(posedge clk_i);
    pins_o <= '{1'b0, 1'b1, 1'b1, 1'b1, io, b, (~^b) ^ badp};
    @(posedge clk_i);
    pins_o.req <= 1'b1;
    wait_ack(1'b1);
    got = db_i;
    pins_o.req <= 1'b0;
    wait_ack(1'b0);
    atn = atn_i;
    pins_o.db <= ~b;
    if (io) interlock = atn_i;
    if (io && b == 8'h0F) recovery = !atn_i;
    if (!io && got == 8'h09 && !interlock) release_bus();
  endtask
endmodule

/* dv/bsmh_initiator_bench.sv */
// Self-checking bench for the initiator-side bus message handler.
// Assumes the target model answers every phase the bench asks for.
`timescale 1ns/1ps
module bsmh_initiator_bench;
  logic clk_i;
  logic rst_n_i;
  bsmh_pkg::bsmh_sw_req_type sw_req;
  bsmh_pkg::bsmh_pins_type pins;
  logic [31:0] rd_data;
  logic [7:0] db;
  logic dbp, oe, ack, atn, prs, prt;
  int failures = 0;
  int n_tests = 0;
  logic [31:0] d;
  logic [7:0] rj [4] = '{8'hC0, 8'h90, 8'h88, 8'h87};
  logic [7:0] rc [4] = '{8'h00, 8'h40, 8'h40, 8'h40};
  logic [7:0] rn [4] = '{8'h01, 8'h01, 8'h02, 8'h03};
  logic [3:0] rm [4] = '{4'hE, 4'h8, 4'hC, 4'hE};
  int n_rs = 0;
  int n_rt = 0;
  bsmh_initiator dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sw_req_i(sw_req), .rd_data_o(rd_data),
    .pins_i(pins), .db_o(db), .dbp_o(dbp), .db_oe_o(oe), .ack_o(ack), .atn_o(atn),
    .ptr_restore_o(prs), .ptr_reset_o(prt));
  bsmh_target_model tgt_u (.clk_i(clk_i), .pins_o(pins), .db_i(db), .ack_i(ack), .atn_i(atn));
  // ==========================================================================
  // Pointer event counters.
  always @(posedge clk_i) begin
    if (prs === 1'b1) n_rs++;
    if (prt === 1'b1) n_rt++;
  end
  // ==========================================================================
  // Access and compare tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    sw_req <= '{1'b1, 1'b0, a, v};
    @(posedge clk_i);
    sw_req <= '0;
  endtask
  task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk_i);
    sw_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_i);
    sw_req <= '0;
    #1 d = rd_data;
    check(d & m, exp);
  endtask
  task automatic min(input logic [7:0] b, input logic badp, input logic exp_atn);
    logic a;
    logic [7:0] g;
    tgt_u.xfer(1'b1, b, badp, a, g);
    if (tgt_u.timeouts != 0) final_report();
    check({31'h0, a}, {31'h0, exp_atn});
  endtask
  task automatic mout(input logic [7:0] exp);
    logic a;
    logic [7:0] g;
    tgt_u.xfer(1'b0, 8'h00, 1'b0, a, g);
    if (tgt_u.timeouts != 0) final_report();
    check({24'h0, g}, {24'h0, exp});
  endtask
  task automatic fresh(input string name);
    $display("test %s done", name);
    tgt_u.release_bus();
    repeat (4) @(posedge clk_i);
    tgt_u.connect();
  endtask
  task automatic final_report();
    failures += tgt_u.timeouts;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog and test sequence.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial begin
    sw_req = '0;
    rst_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdm(bsmh_pkg::ADDR_CTRL, 32'hFF, {24'h0, bsmh_pkg::CTRL_RESET});
    rdm(4'hF, 32'hFFFF_FFFF, 32'h0);
    wr(bsmh_pkg::ADDR_CTRL, 32'h15);
    rdm(bsmh_pkg::ADDR_CTRL, 32'hFF, 32'h15);
    fresh("registers");
    wr(bsmh_pkg::ADDR_CMD, 32'h5A03);
    mout(8'hC5);
    mout(8'h5A);
    check({31'h0, atn}, 32'h0);
    wr(bsmh_pkg::ADDR_CTRL, 32'h19);
    wr(bsmh_pkg::ADDR_CMD, 32'h1);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h10, 32'h10);
    wr(bsmh_pkg::ADDR_CMD, 32'h4);
    wr(bsmh_pkg::ADDR_CTRL, 32'h14);
    wr(bsmh_pkg::ADDR_CMD, 32'h1);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h10, 32'h0);
    mout(8'h85);
    fresh("identify out");
    wr(bsmh_pkg::ADDR_CTRL, 32'h0A);
    wr(bsmh_pkg::ADDR_CMD, 32'h1);
    mout(8'hA2);
    fresh("routine");
    wr(bsmh_pkg::ADDR_CTRL, 32'h0);
    rdm(bsmh_pkg::ADDR_PTR, 32'hFFFF, 32'h0);
    min(tgt_u.ident(3'h3), 1'b0, 1'b0);
    min(8'h0A, 1'b0, 1'b0);
    min(8'h0B, 1'b0, 1'b0);
    rdm(bsmh_pkg::ADDR_PTR, 32'hFFFF, 32'h0201);
    check(n_rs, 1);
    check(n_rt, 2);
    min(8'h0A, 1'b1, 1'b1);
    mout(8'h09);
    min(8'h0A, 1'b0, 1'b0);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h44, 32'h44);
    fresh("reconnect");
    for (int i = 0; i < 4; i++) begin
      min(rj[i], 1'b0, i < 3);
      mout((i < 3) ? 8'h07 : 8'h08);
    end
    min(8'h23, 1'b0, 1'b0);
    min(8'h02, 1'b0, 1'b1);
    mout(8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(bsmh_pkg::ADDR_CTRL, {24'h0, rc[i]});
      min(8'h23, 1'b0, 1'b0);
      min(rn[i], 1'b0, 1'b0);
      rdm(bsmh_pkg::ADDR_RX, 32'hFFF, {20'h0, rm[i], rn[i]});
    end
    fresh("reject and residue");
    wr(bsmh_pkg::ADDR_CTRL, 32'h80);
    min(8'h0F, 1'b0, 1'b1);
    mout(8'h07);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h8, 32'h0);
    wr(bsmh_pkg::ADDR_CTRL, 32'h0);
    min(8'h0F, 1'b0, 1'b0);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h8, 32'h8);
    check({31'h0, tgt_u.recovery}, 32'h1);
    min(8'h07, 1'b0, 1'b0);
    rdm(bsmh_pkg::ADDR_STATUS, 32'h28, 32'h28);
    wr(bsmh_pkg::ADDR_CTRL, 32'h20);
    min(tgt_u.ident(3'h1), 1'b0, 1'b0);
    min(8'h20, 1'b0, 1'b0);
    min(8'h5A, 1'b0, 1'b0);
    rdm(bsmh_pkg::ADDR_PTR, 32'hFFFF, 32'h0303);
    check(n_rs, 3);
    check(n_rt, 3);
    fresh("recovery");
    final_report();
  end
endmodule
bind bsmh_initiator bsmh_initiator_checker chk_u (.clk_i, .rst_n_i, .sw_req_i, .rd_data_o, .pins_i,
  .db_o, .dbp_o, .db_oe_o, .ack_o, .atn_o, .ptr_restore_o, .ptr_reset_o);
